// ==== bench/cada_far.sv ====
// Far-side model: translation buffers and write-back memory port
`timescale 1ns/100ps
module cada_far
  import cada_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic miss_en,
  input wire logic xlat_req,
  input wire logic xlat_unified,
  input wire logic [cada_pkg::VPN_W-1:0] xlat_vpn,
  output logic xlat_done,
  output logic xlat_miss,
  output logic [cada_pkg::TAG_W-1:0] xlat_ppn,
  input wire logic wb_valid,
  input wire logic [cada_pkg::PADDR_W-1:0] wb_addr,
  input wire logic [31:0] wb_data,
  output logic wb_ready,
  output logic [7:0] beats,
  output logic [cada_pkg::PADDR_W-1:0] first_addr,
  output logic [31:0] first_data,
  output logic uni
);
  logic [1:0] wait_q;
  logic tgl_q;
  logic [TAG_W-1:0] map;
  // --------------------------------------------------------------
  // Translation answers, garbage outside the answer cycle
  // --------------------------------------------------------------
  assign map = {xlat_vpn[18:16] ^ xlat_vpn[21:19], xlat_vpn[15:0]};
  assign xlat_ppn = xlat_done ? map : ~map;
  assign xlat_miss = xlat_done ? miss_en : ~miss_en;
  // --------------------------------------------------------------
  // Write-back acceptance, stalls every other cycle when slow
  // --------------------------------------------------------------
  assign wb_ready = wb_valid && (!slow || tgl_q);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wait_q <= 2'h0;
      tgl_q <= 1'b0;
      xlat_done <= 1'b0;
      beats <= 8'h0;
      uni <= 1'b0;
    end else begin
      tgl_q <= ~tgl_q;
      xlat_done <= 1'b0;
      if (xlat_req && !xlat_done) begin
        wait_q <= wait_q + 2'h1;
        if (!slow || wait_q == 2'h2) begin
          xlat_done <= 1'b1;
          wait_q <= 2'h0;
          uni <= xlat_unified;
        end
      end
      if (wb_valid && wb_ready) begin
        beats <= beats + 8'h1;
        if (wb_addr[4:2] == 3'h0) begin
          first_addr <= wb_addr;
          first_data <= wb_data;
        end
      end
    end
  end
endmodule : cada_far

// ==== bench/cada_top_bench.sv ====
// Self-checking bench for the cache array direct access block
`timescale 1ns/100ps
module cada_top_bench;
  import cada_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic [31:0] req_wdata = 32'h0;
  logic translation_on = 1'b0;
  logic slow = 1'b0;
  logic miss_en = 1'b0;
  logic req_ready, rsp_valid, xlat_req, xlat_unified, xlat_done, xlat_miss;
  logic wb_valid, wb_ready, uni;
  logic [31:0] rsp_rdata, wb_data, far_data, rd;
  logic [VPN_W-1:0] xlat_vpn;
  logic [TAG_W-1:0] xlat_ppn;
  logic [PADDR_W-1:0] wb_addr, far_addr;
  logic [7:0] beats, b0;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  localparam logic [31:0] MK_IC = 32'h1fff_fc01;
  localparam logic [31:0] MK_OC = 32'h1fff_fc03;
  always #12.5 clk = ~clk;
  cada_top uut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .translation_on(translation_on), .xlat_req(xlat_req),
    .xlat_unified(xlat_unified), .xlat_vpn(xlat_vpn), .xlat_done(xlat_done),
    .xlat_miss(xlat_miss), .xlat_ppn(xlat_ppn), .wb_valid(wb_valid), .wb_ready(wb_ready),
    .wb_addr(wb_addr), .wb_data(wb_data));
  cada_far far (.clk(clk), .rstn(rstn), .slow(slow), .miss_en(miss_en), .xlat_req(xlat_req),
    .xlat_unified(xlat_unified), .xlat_vpn(xlat_vpn), .xlat_done(xlat_done),
    .xlat_miss(xlat_miss), .xlat_ppn(xlat_ppn), .wb_valid(wb_valid), .wb_addr(wb_addr),
    .wb_data(wb_data), .wb_ready(wb_ready), .beats(beats), .first_addr(far_addr),
    .first_data(far_data), .uni(uni));
  // --------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] ad(input logic [7:0] r, input logic [1:0] w,
      input logic [7:0] e, input logic [2:0] l);
    return {r, 9'h0, w, e, l, 2'b00};
  endfunction : ad
  function automatic logic [31:0] tw(input logic [18:0] t, input logic d, input logic v);
    return {3'h5, t, 8'h0, d, v};
  endfunction : tw
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 300) chk("response", 32'h1, 32'h0);
    rd = rsp_rdata;
    @(posedge clk);
    #1;
  endtask : acc
  task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] m,
      input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(n, e & m, rd & m);
  endtask : rdchk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_ic_tag();
    acc(1'b1, ad(8'hf0, 2'h2, 8'h05, 3'h0), tw(19'h5a5a5, 1'b0, 1'b1));
    rdchk("ic tag", ad(8'hf0, 2'h2, 8'h05, 3'h2), MK_IC, tw(19'h5a5a5, 1'b0, 1'b1));
    rdchk("ic way0", ad(8'hf0, 2'h0, 8'h05, 3'h0), 32'h1, 32'h0);
  endtask : t_ic_tag
  task automatic t_data();
    logic [7:0] r;
    for (int i = 0; i < 2; i++) begin
      r = i ? 8'hf5 : 8'hf1;
      acc(1'b1, ad(r, 2'h3, 8'hff, 3'h0), {r, 24'h00a0});
      acc(1'b1, ad(r, 2'h3, 8'hff, 3'h7), {r, 24'h07b7});
      rdchk("data w0", ad(r, 2'h3, 8'hff, 3'h0), '1, {r, 24'h00a0});
      rdchk("data w7", ad(r, 2'h3, 8'hff, 3'h7), '1, {r, 24'h07b7});
    end
    rdchk("unmapped", ad(8'hf2, 2'h0, 8'h00, 3'h0), '1, 32'h0);
  endtask : t_data
  task automatic t_oc_plain();
    acc(1'b1, ad(8'hf4, 2'h1, 8'h03, 3'h0), tw(19'h12345, 1'b0, 1'b1));
    rdchk("oc tag", ad(8'hf4, 2'h1, 8'h03, 3'h0), MK_OC, tw(19'h12345, 1'b0, 1'b1));
    acc(1'b1, ad(8'hf5, 2'h1, 8'h03, 3'h0), 32'hc0de_0001);
    rdchk("dirty kept", ad(8'hf4, 2'h1, 8'h03, 3'h0), 32'h3, 32'h1);
    b0 = beats;
    acc(1'b1, ad(8'hf4, 2'h1, 8'h03, 3'h0), tw(19'h12345, 1'b1, 1'b1));
    chk("clean no wb", b0, beats);
    slow = 1'b1;
    acc(1'b1, ad(8'hf4, 2'h1, 8'h03, 3'h0), tw(19'h2abcd, 1'b0, 1'b1));
    chk("wb beats", b0 + 8'h8, beats);
    chk("wb addr", {19'h12345, 5'h03, 5'h00}, far_addr);
    chk("wb data", 32'hc0de_0001, far_data);
    rdchk("oc new tag", ad(8'hf4, 2'h1, 8'h03, 3'h0), MK_OC, tw(19'h2abcd, 1'b0, 1'b1));
  endtask : t_oc_plain
  task automatic t_oc_assoc();
    acc(1'b1, ad(8'hf4, 2'h1, 8'h03, 3'h0), tw(19'h2abcd, 1'b1, 1'b1));
    b0 = beats;
    acc(1'b1, ad(8'hf4, 2'h0, 8'h03, 3'h2), tw(19'h2abcd, 1'b0, 1'b1));
    chk("assoc wb", b0 + 8'h8, beats);
    rdchk("assoc flags", ad(8'hf4, 2'h1, 8'h03, 3'h0), 32'h3, 32'h1);
    acc(1'b1, ad(8'hf4, 2'h0, 8'h03, 3'h2), tw(19'h2abcc, 1'b0, 1'b0));
    rdchk("no match", ad(8'hf4, 2'h1, 8'h03, 3'h0), 32'h3, 32'h1);
    translation_on = 1'b1;
    miss_en = 1'b1;
    acc(1'b1, ad(8'hf4, 2'h0, 8'h03, 3'h2), {3'h3, 19'h2abcd ^ 19'h30000, 10'h0});
    chk("unified", 32'h1, {31'h0, uni});
    rdchk("xlat miss", ad(8'hf4, 2'h1, 8'h03, 3'h0), 32'h3, 32'h1);
    miss_en = 1'b0;
    acc(1'b1, ad(8'hf4, 2'h0, 8'h03, 3'h2), {3'h3, 19'h2abcd ^ 19'h30000, 10'h0});
    rdchk("xlat hit", ad(8'hf4, 2'h1, 8'h03, 3'h0), MK_OC, tw(19'h2abcd, 1'b0, 1'b0));
    chk("clean inval", b0 + 8'h8, beats);
  endtask : t_oc_assoc
  task automatic t_ic_assoc();
    miss_en = 1'b1;
    acc(1'b1, ad(8'hf0, 2'h0, 8'h05, 3'h2), {3'h6, 19'h5a5a5 ^ 19'h60000, 10'h0});
    chk("instruction_translation_buffer", 32'h0, {31'h0, uni});
    rdchk("ic miss", ad(8'hf0, 2'h2, 8'h05, 3'h0), 32'h1, 32'h1);
    miss_en = 1'b0;
    acc(1'b1, ad(8'hf0, 2'h0, 8'h05, 3'h2), {3'h6, 19'h5a5a5 ^ 19'h60000, 10'h0});
    rdchk("ic inval", ad(8'hf0, 2'h2, 8'h05, 3'h0), MK_IC, tw(19'h5a5a5, 1'b0, 1'b0));
  endtask : t_ic_assoc
  // --------------------------------------------------------------
  // Main sequence and timeout
  // --------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1;
    chk("reset out", 32'h8, {28'h0, req_ready, rsp_valid, wb_valid, xlat_req});
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(posedge clk);
    #1;
    t_ic_tag();
    t_data();
    t_oc_plain();
    t_oc_assoc();
    t_ic_assoc();
    finish_test();
  end
endmodule : cada_top_bench

// ==== core/cada_pkg.sv ====
// Constants and types shared by the cache array direct access block
package cada_pkg;
  // --------------------------------------------------------------
  // Address regions and field positions
  // --------------------------------------------------------------
  localparam logic [7:0] REG_IC_TAG = 8'hf0;
  localparam logic [7:0] REG_IC_DAT = 8'hf1;
  localparam logic [7:0] REG_OC_TAG = 8'hf4;
  localparam logic [7:0] REG_OC_DAT = 8'hf5;
  localparam int REGION_HI = 31;
  localparam int REGION_LO = 24;
  localparam int WAY_HI = 14;
  localparam int WAY_LO = 13;
  localparam int ENT_HI = 12;
  localparam int ENT_LO = 5;
  localparam int LW_HI = 4;
  localparam int LW_LO = 2;
  localparam int ASSOC_BIT = 3;
  // --------------------------------------------------------------
  // Data field layout
  // --------------------------------------------------------------
  localparam int TAG_HI = 28;
  localparam int TAG_LO = 10;
  localparam int VA_HI = 31;
  localparam int DIRTY_BIT = 1;
  localparam int VALID_BIT = 0;
  localparam int TAG_W = TAG_HI - TAG_LO + 1;
  localparam int VPN_W = VA_HI - TAG_LO + 1;
  localparam int WAY_W = WAY_HI - WAY_LO + 1;
  localparam int ENT_W = ENT_HI - ENT_LO + 1;
  localparam int LW_W = LW_HI - LW_LO + 1;
  localparam int LINE_IDX_W = TAG_LO - ENT_LO;
  localparam int PADDR_W = TAG_HI + 1;
  // --------------------------------------------------------------
  // Reset values and geometry
  // --------------------------------------------------------------
  localparam int WAYS_DEF = 4;
  localparam int ENTRIES_DEF = 256;
  localparam int LINE_WORDS_DEF = 8;
  localparam logic [LW_W-1:0] LW_LAST = 3'h7;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_XLAT = 3'b001,
    ST_CMP = 3'b010,
    ST_WB = 3'b011,
    ST_UPD = 3'b100
  } cada_state_t;
endpackage : cada_pkg

// ==== core/cada_ram.sv ====
// Data array storage with one write port and one asynchronous read port
`timescale 1ns/100ps
module cada_ram #(
  parameter int W = 32,
  parameter int DEPTH = 8192
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem_q [DEPTH];

  if (DEPTH < 2) begin : g_bad_depth
    $error("cada_ram depth too small");
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  assign rdata = mem_q[raddr];
endmodule : cada_ram

// ==== core/cada_top.sv ====
// Direct access port to instruction and operand cache tag and data arrays
// Contract
// - Region f0 selects instruction_cache tags; way, entry, assoc bit, tag and valid
// - Instruction tag read returns tag and valid, never compares
// - Plain instruction tag write stores tag and valid at way and entry
// - Assoc instruction tag write ignores way, compares all ways, translates first
// - Assoc instruction write changes only valid, only in a matching valid way
// - Instruction translation miss or no match: no exception, no change
// - Region f1 selects instruction data; bits 4:2 pick the longword
// - Region f4 selects operand_cache tags with way, entry and assoc bit
// - Operand tag data: tag in 28:10, dirty bit 1, valid bit 0
// - Tag is 19 bits; bits 31:29 only feed associative translation
// - Operand tag read returns tag, dirty and valid, never compares
// - Plain operand tag write over dirty valid line writes back first
// - Assoc operand tag write ignores way, compares all, unified translation
// - Assoc operand write updates flags only in a matching valid way
// - Assoc hit on dirty line clearing valid or dirty writes line back
// - Unified translation miss or no match: no exception, no write
// - Region f5 selects operand data with way, entry and longword
// - Operand data write leaves the dirty flag alone
`timescale 1ns/100ps
module cada_top #(
  parameter int WAYS = cada_pkg::WAYS_DEF,
  parameter int ENTRIES = cada_pkg::ENTRIES_DEF,
  parameter int LINE_WORDS = cada_pkg::LINE_WORDS_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  input wire logic translation_on,
  output logic xlat_req,
  output logic xlat_unified,
  output logic [cada_pkg::VPN_W-1:0] xlat_vpn,
  input wire logic xlat_done,
  input wire logic xlat_miss,
  input wire logic [cada_pkg::TAG_W-1:0] xlat_ppn,
  output logic wb_valid,
  input wire logic wb_ready,
  output logic [cada_pkg::PADDR_W-1:0] wb_addr,
  output logic [31:0] wb_data
);
  import cada_pkg::*;

  // --------------------------------------------------------------
  // Geometry check
  // --------------------------------------------------------------
  localparam int TIDX_W = WAY_W + ENT_W;
  localparam int DIDX_W = TIDX_W + LW_W;
  localparam int TDEPTH = WAYS * ENTRIES;
  localparam int DDEPTH = TDEPTH * LINE_WORDS;

  if (WAYS != (1 << WAY_W) || ENTRIES != (1 << ENT_W) || LINE_WORDS != (1 << LW_W))
  begin : g_bad_geom
    $error("cada_top geometry does not match the address fields");
  end

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  cada_state_t state_q, state_d;
  logic is_oc_q;
  logic assoc_q;
  logic [WAY_W-1:0] way_q;
  logic [ENT_W-1:0] ent_q;
  logic [31:0] wdata_q;
  logic [TAG_W-1:0] cmp_tag_q;
  logic [LW_W-1:0] wb_cnt_q;
  logic rsp_valid_q;
  logic [31:0] rsp_rdata_q;
  logic [TAG_W-1:0] ic_tag_q [TDEPTH];
  logic [TAG_W-1:0] oc_tag_q [TDEPTH];
  logic [TDEPTH-1:0] ic_v_q;
  logic [TDEPTH-1:0] oc_v_q;
  logic [TDEPTH-1:0] oc_d_q;

  // --------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------
  wire [7:0] region = req_addr[REGION_HI:REGION_LO];
  wire sel_ic_tag = (region == REG_IC_TAG);
  wire sel_ic_dat = (region == REG_IC_DAT);
  wire sel_oc_tag = (region == REG_OC_TAG);
  wire sel_oc_dat = (region == REG_OC_DAT);
  wire sel_none = !(sel_ic_tag || sel_ic_dat || sel_oc_tag || sel_oc_dat);
  wire accept = req_valid && req_ready;
  wire acc_rd = accept && !req_write;
  wire acc_tag_wr = accept && req_write && (sel_ic_tag || sel_oc_tag);
  wire req_assoc = req_addr[ASSOC_BIT];
  wire [TIDX_W-1:0] req_tidx = {req_addr[WAY_HI:WAY_LO], req_addr[ENT_HI:ENT_LO]};
  wire [DIDX_W-1:0] req_didx = {req_tidx, req_addr[LW_HI:LW_LO]};

  // --------------------------------------------------------------
  // Associative compare over every way of the entry
  // --------------------------------------------------------------
  logic [WAYS-1:0] hit_vec;
  for (genvar w = 0; w < WAYS; w++) begin : g_cmp
    wire [TIDX_W-1:0] idx = {WAY_W'(w), ent_q};
    wire ic_hit = ic_v_q[idx] && (ic_tag_q[idx] == cmp_tag_q);
    wire oc_hit = oc_v_q[idx] && (oc_tag_q[idx] == cmp_tag_q);
    assign hit_vec[w] = is_oc_q ? oc_hit : ic_hit;
  end

  function automatic logic [WAY_W-1:0] first_hit(input logic [WAYS-1:0] v);
    logic [WAY_W-1:0] r;
    r = '0;
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i[WAY_W-1:0];
      end
    end
    return r;
  endfunction : first_hit

  wire any_hit = |hit_vec;
  wire [WAY_W-1:0] way_sel = assoc_q ? first_hit(hit_vec) : way_q;
  wire in_cmp = (state_q == ST_CMP);
  wire [WAY_W-1:0] cur_way = in_cmp ? way_sel : way_q;
  wire [TIDX_W-1:0] tgt_idx = {cur_way, ent_q};
  wire old_v = oc_v_q[tgt_idx];
  wire old_d = oc_d_q[tgt_idx];
  wire new_v = wdata_q[VALID_BIT];
  wire new_d = wdata_q[DIRTY_BIT];
  wire do_upd = !assoc_q || any_hit;
  wire clr_flag = !new_v || !new_d;
  wire wb_plain = !assoc_q && old_v && old_d;
  wire wb_assoc = assoc_q && any_hit && old_d && clr_flag;
  wire need_wb = is_oc_q && (wb_plain || wb_assoc);

  // --------------------------------------------------------------
  // Write-back beats
  // --------------------------------------------------------------
  wire in_wb = (state_q == ST_WB);
  wire wb_fire = wb_valid && wb_ready;
  wire wb_last = wb_fire && (wb_cnt_q == LW_LAST);
  wire [DIDX_W-1:0] wb_didx = {tgt_idx, wb_cnt_q};

  // --------------------------------------------------------------
  // Data arrays
  // --------------------------------------------------------------
  wire ic_dat_we = accept && req_write && sel_ic_dat;
  wire oc_dat_we = accept && req_write && sel_oc_dat;
  wire [DIDX_W-1:0] oc_raddr = in_wb ? wb_didx : req_didx;
  logic [31:0] ic_dat_rd;
  logic [31:0] oc_dat_rd;

  cada_ram #(.W(32), .DEPTH(DDEPTH)) u_ic_dat (
    .clk(clk),
    .we(ic_dat_we),
    .waddr(req_didx),
    .wdata(req_wdata),
    .raddr(req_didx),
    .rdata(ic_dat_rd)
  );

  cada_ram #(.W(32), .DEPTH(DDEPTH)) u_oc_dat (
    .clk(clk),
    .we(oc_dat_we),
    .waddr(req_didx),
    .wdata(req_wdata),
    .raddr(oc_raddr),
    .rdata(oc_dat_rd)
  );

  // --------------------------------------------------------------
  // Read data selection
  // --------------------------------------------------------------
  wire [31:0] ic_tag_word = {3'h0, ic_tag_q[req_tidx], 9'h000, ic_v_q[req_tidx]};
  wire [31:0] oc_tag_word = {3'h0, oc_tag_q[req_tidx], 8'h00,
                             oc_d_q[req_tidx], oc_v_q[req_tidx]};
  wire [31:0] rd_word = sel_ic_tag ? ic_tag_word :
                        sel_oc_tag ? oc_tag_word :
                        sel_ic_dat ? ic_dat_rd :
                        sel_oc_dat ? oc_dat_rd : RDATA_RST;

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  wire xlat_fail = xlat_req && xlat_done && xlat_miss;
  wire tag_upd = (in_cmp && do_upd && !need_wb) || (state_q == ST_UPD);
  wire finish = (in_cmp && !need_wb) || (state_q == ST_UPD) || xlat_fail;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (acc_tag_wr) begin
          state_d = (req_assoc && translation_on) ? ST_XLAT : ST_CMP;
        end
      end
      ST_XLAT: begin
        if (xlat_done) begin
          state_d = xlat_miss ? ST_IDLE : ST_CMP;
        end
      end
      ST_CMP: begin
        state_d = need_wb ? ST_WB : ST_IDLE;
      end
      ST_WB: begin
        if (wb_last) begin
          state_d = ST_UPD;
        end
      end
      ST_UPD: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      is_oc_q <= 1'b0;
      assoc_q <= 1'b0;
      way_q <= '0;
      ent_q <= '0;
      wdata_q <= '0;
      cmp_tag_q <= '0;
    end else begin
      state_q <= state_d;
      if (acc_tag_wr) begin
        is_oc_q <= sel_oc_tag;
        assoc_q <= req_assoc;
        way_q <= req_addr[WAY_HI:WAY_LO];
        ent_q <= req_addr[ENT_HI:ENT_LO];
        wdata_q <= req_wdata;
        cmp_tag_q <= req_wdata[TAG_HI:TAG_LO];
      end else if (xlat_req && xlat_done && !xlat_miss) begin
        cmp_tag_q <= xlat_ppn;
      end else if (in_cmp) begin
        way_q <= way_sel;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !in_wb) begin
      wb_cnt_q <= '0;
    end else if (wb_fire) begin
      wb_cnt_q <= wb_cnt_q + 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Tag array update
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ic_v_q <= '0;
      oc_v_q <= '0;
      oc_d_q <= '0;
    end else if (tag_upd && !is_oc_q) begin
      ic_v_q[tgt_idx] <= new_v;
    end else if (tag_upd) begin
      oc_v_q[tgt_idx] <= new_v;
      oc_d_q[tgt_idx] <= new_d;
    end
  end

  always_ff @(posedge clk) begin
    if (tag_upd && !assoc_q && !is_oc_q) begin
      ic_tag_q[tgt_idx] <= wdata_q[TAG_HI:TAG_LO];
    end
    if (tag_upd && !assoc_q && is_oc_q) begin
      oc_tag_q[tgt_idx] <= wdata_q[TAG_HI:TAG_LO];
    end
  end

  // --------------------------------------------------------------
  // Responses
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= RDATA_RST;
    end else begin
      rsp_valid_q <= (accept && !acc_tag_wr) || finish;
      if (acc_rd) begin
        rsp_rdata_q <= rd_word;
      end else if (accept || finish) begin
        rsp_rdata_q <= RDATA_RST;
      end
    end
  end

  assign req_ready = (state_q == ST_IDLE);
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign xlat_req = (state_q == ST_XLAT);
  assign xlat_unified = is_oc_q;
  assign xlat_vpn = wdata_q[VA_HI:TAG_LO];
  assign wb_valid = in_wb;
  assign wb_addr = {oc_tag_q[tgt_idx], ent_q[LINE_IDX_W-1:0], wb_cnt_q, 2'b00};
  assign wb_data = oc_dat_rd;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  chk_read_answer: assert property (@(posedge clk) disable iff (!rstn)
    acc_rd |=> rsp_valid)
    else $error("read not answered in one cycle");

  chk_ic_tag_read: assert property (@(posedge clk) disable iff (!rstn)
    acc_rd && sel_ic_tag |=> rsp_rdata[VALID_BIT] == $past(ic_v_q[req_tidx]))
    else $error("instruction tag read valid wrong");

  chk_oc_tag_read: assert property (@(posedge clk) disable iff (!rstn)
    acc_rd && sel_oc_tag |=> rsp_rdata[1:0] == $past({oc_d_q[req_tidx], oc_v_q[req_tidx]}))
    else $error("operand tag read flags wrong");

  chk_assoc_miss: assert property (@(posedge clk) disable iff (!rstn)
    in_cmp && assoc_q && !any_hit |-> !tag_upd ##1 !wb_valid && rsp_valid)
    else $error("associative miss changed state");

  chk_xlat_fail: assert property (@(posedge clk) disable iff (!rstn)
    xlat_fail |=> req_ready && !wb_valid && $stable(oc_v_q) && $stable(ic_v_q))
    else $error("translation miss changed state");

  chk_plain_wb: assert property (@(posedge clk) disable iff (!rstn)
    in_cmp && !assoc_q && is_oc_q && old_v && old_d |-> !tag_upd ##1 wb_valid)
    else $error("dirty line not written back");

  chk_wb_order: assert property (@(posedge clk) disable iff (!rstn)
    wb_last |=> tag_upd ##1 rsp_valid && req_ready)
    else $error("tag update not after write-back");

  chk_wb_tag: assert property (@(posedge clk) disable iff (!rstn)
    wb_valid |-> wb_addr[TAG_HI:TAG_LO] == oc_tag_q[{way_q, ent_q}])
    else $error("write-back address wrong");

  chk_wb_hold: assert property (@(posedge clk) disable iff (!rstn)
    wb_valid && !wb_ready |=> wb_valid && $stable(wb_addr) && $stable(wb_data))
    else $error("write-back beat not held");

  chk_dat_dirty: assert property (@(posedge clk) disable iff (!rstn)
    oc_dat_we |=> $stable(oc_d_q))
    else $error("data write touched dirty flag");

  chk_unmapped: assert property (@(posedge clk) disable iff (!rstn)
    acc_rd && sel_none |=> rsp_rdata == RDATA_RST)
    else $error("unmapped read not zero");
endmodule : cada_top
